// file: hdl/pwm_tester.sv
/*
 * Memory tester: runs the sequential, seven-read, single-pass write, manual
 * and worst-case disturb patterns against the memory unit, stopping on the
 * first mismatch.
 * Assumes the memory's open-collector outputs are pulled up externally.
 */
`timescale 1ns/1ps

// Overview of operation
// (R1) Read-done must fall within 500 ns.
// (R2) Read-done low between 250 and 450 ns.
// (R3) Data falls no later than read-done.
// (R4) Data held 150 ns past read-done rise.
// (R5) Memory stores 4096 words, reads back writes.
// (R6) Memory acts only with select 1111.
// (R7) Contents survive power removal.
// (R8) Seven reads return unchanged data.
// (R9) Cycles work at 600 kHz strobe rate.
// (R10) Even-line zeros survive odd-line ones writes.
// (R11) Sequential: write0, read, write1, read, advance.
// (R12) Cycle until mismatch, then stop.
// (R13) Seven-read mode reads each value seven times.
// (R14) Disturb test runs four swapped groups.
// (R15) Single pass writes all addresses once.
// (R16) Present 12 address, 18 data bits.
// (R17) Outputs open collector, need pull-up.
// (R18) One access per strobe, level picks direction.
// (R19) Write cycles give no read-done.
module pwm_tester
   import pwm_pkg::*;
(
   input  wire logic                core_clk,     // 40 MHz clock.
   input  wire logic                resetn,       // Async reset, active low.
   input  wire logic                clk_en,       // Freezes state while low.
   input  wire logic                run,          // Start pulse for a test.
   input  wire logic                halt,         // Stop pulse.
   input  wire logic                next_group,   // Advance disturb group.
   input  wire pwm_pkg::pwm_pat_e   pattern,      // Test pattern choice.
   input  wire logic                read_seven,   // Seven reads per value.
   input  wire logic                man_read,     // Manual/single pass: read.
   input  wire logic [ADDR_W-1:0]   man_addr,     // Manual address.
   input  wire logic [DATA_W-1:0]   man_data,     // Manual data.
   input  wire logic [SEL_W-1:0]    sel_code,     // Unit-select code to drive.
   output logic                     active,       // Test running.
   output logic                     error,        // Mismatch seen, sticky.
   output logic [ADDR_W-1:0]        err_addr,     // Address of the mismatch.
   output logic [1:0]               group,        // Disturb group number.
   output logic                     start_pulse,  // Start strobe pin.
   output logic                     wr_n_rd,      // Read/write pin, high read.
   output logic [ADDR_W-1:0]        mem_addr,     // Address pins.
   output logic [DATA_W-1:0]        data_in_bits, // Data-input pins.
   output logic [SEL_W-1:0]         unit_sel,     // Unit-select pins.
   input  wire logic                done_n,       // Read-done pin, pulled up.
   input  wire logic [DATA_W-1:0]   dout_n        // Data pins, pulled up.
);
   typedef enum logic [2:0] {
      PWM_IDLE,
      PWM_ISSUE,
      PWM_WAIT,
      PWM_STOP
   } pwm_state_e;

   // Disturb sub-phases: hammer all, write zeros on one line parity, cycle.
   typedef enum logic [1:0] {
      PWM_WC_HAMMER,
      PWM_WC_CLEAR,
      PWM_WC_CYCLE
   } pwm_wc_e;

   pwm_state_e        state;
   pwm_state_e        next_state;
   pwm_wc_e           wc;
   logic [ADDR_W-1:0] addr;
   logic [2:0]        step;
   logic [2:0]        reads;
   logic [HAMMER_LOG2-1:0] passes;
   pwm_cyc_if         cyc ();

   // Group bit 0 swaps even and odd lines, bit 1 swaps ones and zeros.
   wire              swap_par = group[0];
   wire              swap_val = group[1];
   wire [DATA_W-1:0] hi_val = swap_val ? ZEROS : ONES;
   wire [DATA_W-1:0] lo_val = swap_val ? ONES : ZEROS;
   wire              is_even = (addr[0] == swap_par);
   wire              seq_read = step[0];
   wire [DATA_W-1:0] seq_data = step[1] ? ONES : ZEROS;
   wire [2:0]        reads_need = read_seven ? 3'(READ_REPEAT) : 3'd1;
   wire              addr_end = (addr == ADDR_LAST);

   // Request decode for the current pattern step.
   wire wc_read = (wc == PWM_WC_CYCLE) & is_even;
   // The clear pass writes every word: lo_val on the even line, hi_val again on odd-line words.
   wire [DATA_W-1:0] wc_data = (wc == PWM_WC_HAMMER) ? hi_val
                             : (is_even ? lo_val : hi_val); // R10
   wire next_is_read = (pattern == PWM_PAT_SEQ) ? seq_read
                     : (pattern == PWM_PAT_WORST) ? wc_read
                     : man_read; // R18
   wire [DATA_W-1:0] next_data = (pattern == PWM_PAT_SEQ) ? seq_data
                               : (pattern == PWM_PAT_WORST) ? wc_data
                               : man_data;
   wire [ADDR_W-1:0] next_addr = (pattern == PWM_PAT_MANUAL) ? man_addr : addr;

   assign cyc.req = (state == PWM_ISSUE);
   assign cyc.is_read = next_is_read;
   assign cyc.addr = next_addr; // R16
   assign cyc.wdata = next_data; // R16
   assign unit_sel = sel_code; // R6

   // Sequence step completion decode.
   wire seq_step_last = (step == 3'd3) & (reads == reads_need - 3'd1);
   wire one_shot = (pattern == PWM_PAT_MANUAL) | ((pattern == PWM_PAT_SINGLE) & addr_end); // R15
   wire wc_stay = (wc == PWM_WC_CYCLE) & ~addr_end;

   always_comb begin
      next_state = state;
      unique case (state)
         PWM_IDLE: if (run) next_state = PWM_ISSUE;
         PWM_ISSUE: if (cyc.ready) next_state = PWM_WAIT;
         PWM_WAIT: begin
            if (cyc.done) begin
               if (cyc.fail || halt) next_state = PWM_STOP; // R12
               else if (one_shot) next_state = PWM_STOP;
               else next_state = PWM_ISSUE;
            end
         end
         PWM_STOP: if (run) next_state = PWM_ISSUE;
      endcase
      if (halt && state != PWM_WAIT) next_state = PWM_STOP;
   end

   // Main sequencer state.
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         state <= PWM_IDLE;
      end else if (clk_en) begin
         state <= next_state;
      end
   end

   // Error flag and address of the first mismatch.
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         error <= 1'b0;
         err_addr <= '0;
      end else if (clk_en) begin
         if (state == PWM_WAIT && cyc.done && cyc.fail) begin
            error <= 1'b1;
            err_addr <= next_addr;
         end else if (run && state != PWM_WAIT) begin
            error <= 1'b0;
         end
      end
   end

   // Pattern position: address, step, read count, disturb phase and group.
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         addr <= '0;
         step <= '0;
         reads <= '0;
         passes <= '0;
         wc <= PWM_WC_HAMMER;
         group <= '0;
      end else if (clk_en) begin
         if (state != PWM_WAIT && run) begin
            addr <= '0;
            step <= '0;
            reads <= '0;
            passes <= '0;
            wc <= PWM_WC_HAMMER;
            group <= '0;
         end else if (state != PWM_WAIT && next_group && pattern == PWM_PAT_WORST) begin
            group <= group + 2'd1; // R14
            addr <= '0;
            passes <= '0;
            wc <= PWM_WC_HAMMER;
         end else if (state == PWM_WAIT && cyc.done && !cyc.fail) begin
            unique case (pattern)
               PWM_PAT_SEQ: begin
                  if (seq_read && reads != reads_need - 3'd1) begin
                     reads <= reads + 3'd1; // R13
                  end else begin
                     reads <= '0;
                     step <= seq_step_last ? 3'd0 : step + 3'd1; // R11
                     if (seq_step_last) addr <= addr + 1'b1;
                  end
               end
               PWM_PAT_WORST: begin
                  addr <= addr + 1'b1;
                  if (addr_end) begin
                     unique case (wc)
                        PWM_WC_HAMMER: begin
                           passes <= passes + 1'b1;
                           if (passes == '1) wc <= PWM_WC_CLEAR;
                        end
                        PWM_WC_CLEAR: wc <= PWM_WC_CYCLE;
                        PWM_WC_CYCLE: wc <= PWM_WC_CYCLE;
                     endcase
                  end
               end
               default: addr <= addr + 1'b1;
            endcase
         end
      end
   end

   wire unused_stay = wc_stay;
   assign active = (state == PWM_ISSUE) | (state == PWM_WAIT);

   pwm_cycle u_cycle (
      .core_clk     (core_clk),
      .resetn       (resetn),
      .clk_en       (clk_en),
      .cyc          (cyc.eng),
      .start_pulse  (start_pulse),
      .wr_n_rd      (wr_n_rd),
      .mem_addr     (mem_addr),
      .data_in_bits (data_in_bits),
      .done_n       (done_n),
      .dout_n       (dout_n)
   );
endmodule

// file: inc/pwm_pkg.sv
/*
 * Package for the memory tester: pin widths, timing constants converted to
 * clock cycles, pattern modes and the memory size.
 * Assumes a 40 MHz core clock.
 */
package pwm_pkg;
   localparam int ADDR_W = 12;
   localparam int DATA_W = 18;
   localparam int SEL_W = 4;
   localparam int WORDS = 4096;
   localparam int CLK_PERIOD_PS = 25000;
   // Tester cycle period at 600 kHz, in ns (least spacing between strobes).
   localparam int CYCLE_NS = 1667;
   localparam int CYCLE_CLKS = (CYCLE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   // Start strobe width, in ns.
   localparam int STROBE_NS = 450;
   localparam int STROBE_CLKS = (STROBE_NS * 1000) / CLK_PERIOD_PS;
   // Latest read-done after the strobe edge, in ns.
   localparam int DONE_MAX_NS = 500;
   localparam int DONE_MAX_CLKS = (DONE_MAX_NS * 1000) / CLK_PERIOD_PS;
   // Read-done width bounds, in ns.
   localparam int DONE_MIN_W_NS = 250;
   localparam int DONE_MIN_W_CLKS = (DONE_MIN_W_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int DONE_MAX_W_NS = 450;
   localparam int DONE_MAX_W_CLKS = (DONE_MAX_W_NS * 1000) / CLK_PERIOD_PS;
   // Data hold after the trailing edge of read-done, in ns.
   localparam int HOLD_NS = 150;
   localparam int HOLD_CLKS = (HOLD_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int READ_REPEAT = 7;
   localparam int HAMMER_LOG2 = 10;
   localparam int CNT_W = 12;
   localparam logic [SEL_W-1:0] SEL_ON = 4'hF;
   localparam logic [ADDR_W-1:0] ADDR_LAST = 12'hFFF;
   localparam logic [DATA_W-1:0] ONES = 18'h3FFFF;
   localparam logic [DATA_W-1:0] ZEROS = 18'h00000;

   typedef enum logic [1:0] {
      PWM_PAT_SEQ,
      PWM_PAT_SINGLE,
      PWM_PAT_WORST,
      PWM_PAT_MANUAL
   } pwm_pat_e;
endpackage

// file: inc/pwm_cyc_if.sv
/*
 * Interface between the pattern sequencer and the access-cycle engine.
 * Assumes both ends share core_clk.
 */
`timescale 1ns/1ps
interface pwm_cyc_if;
   logic                      req;
   logic                      ready;
   logic                      is_read;
   logic [pwm_pkg::ADDR_W-1:0] addr;
   logic [pwm_pkg::DATA_W-1:0] wdata;
   logic                      done;
   logic                      fail;
   logic [pwm_pkg::DATA_W-1:0] rdata;

   modport seq (output req, is_read, addr, wdata, input ready, done, fail, rdata);
   modport eng (input req, is_read, addr, wdata, output ready, done, fail, rdata);
endinterface

// file: hdl/pwm_cycle.sv
/*
 * Access-cycle engine: drives one start strobe per request, with address,
 * data and read/write held across it, and checks read timing and data.
 * Assumes pin inputs are synchronous to core_clk and the pull-ups resolved.
 */
`timescale 1ns/1ps
module pwm_cycle
   import pwm_pkg::*;
(
   input  wire logic              core_clk,    // 40 MHz clock.
   input  wire logic              resetn,      // Async reset, active low.
   input  wire logic              clk_en,      // Freezes state while low.
   pwm_cyc_if.eng                 cyc,         // Request from the sequencer.
   output logic                   start_pulse, // Start strobe to the memory.
   output logic                   wr_n_rd,     // High for read.
   output logic [ADDR_W-1:0]      mem_addr,    // Address pins.
   output logic [DATA_W-1:0]      data_in_bits,// Data pins to the memory.
   input  wire logic              done_n,      // Read-done, active low.
   input  wire logic [DATA_W-1:0] dout_n       // Data outputs, low for one.
);
   logic [CNT_W-1:0] cnt;
   logic [CNT_W-1:0] done_at;
   logic [CNT_W-1:0] rise_at;
   logic             busy;
   logic             seen;
   logic             ended;
   logic             bad;
   logic             done_q;
   logic [DATA_W-1:0] cap;

   wire done_lo = ~done_n;
   wire done_rise = done_q & ~done_lo;
   wire last = (cnt == CNT_W'(CYCLE_CLKS - 1));
   // Data must already be low when read-done falls, and stay low HOLD after it rises.
   wire early_data = done_lo & ~done_q & ((~dout_n) != cyc.wdata); // R3
   wire hold_bad = ended & (cnt < rise_at + CNT_W'(HOLD_CLKS)) & ((~dout_n) != cap); // R4
   wire late_done = cyc.is_read & ~seen & (cnt == CNT_W'(DONE_MAX_CLKS + 1)); // R1
   wire width_bad = done_rise & ((cnt - done_at < CNT_W'(DONE_MIN_W_CLKS))
                    | (cnt - done_at > CNT_W'(DONE_MAX_W_CLKS + 1))); // R2
   wire wr_done = ~cyc.is_read & done_lo; // R19

   assign cyc.ready = ~busy;
   assign cyc.rdata = cap;

   // One cycle per request; the strobe spans the first STROBE_CLKS cycles.
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         busy <= 1'b0;
         cnt <= '0;
         start_pulse <= 1'b0;
         wr_n_rd <= 1'b0;
         mem_addr <= '0;
         data_in_bits <= '0;
      end else if (clk_en) begin
         if (!busy && cyc.req) begin
            busy <= 1'b1;
            cnt <= '0;
            start_pulse <= 1'b1;
            wr_n_rd <= cyc.is_read;
            mem_addr <= cyc.addr;
            data_in_bits <= cyc.wdata;
         end else if (busy) begin
            cnt <= cnt + 1'b1;
            if (cnt == CNT_W'(STROBE_CLKS - 1)) begin
               start_pulse <= 1'b0;
            end
            if (last) begin
               busy <= 1'b0;
            end
         end
      end
   end

   // Read-side watch: capture data on the falling edge of read-done.
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         done_q <= 1'b0;
         seen <= 1'b0;
         ended <= 1'b0;
         bad <= 1'b0;
         done_at <= '0;
         rise_at <= '0;
         cap <= '0;
         cyc.done <= 1'b0;
         cyc.fail <= 1'b0;
      end else if (clk_en) begin
         done_q <= busy & done_lo;
         cyc.done <= 1'b0;
         if (!busy) begin
            seen <= 1'b0;
            ended <= 1'b0;
            bad <= 1'b0;
         end else begin
            if (done_lo && !done_q) begin
               seen <= 1'b1;
               done_at <= cnt;
               cap <= ~dout_n;
            end
            if (done_rise) begin
               ended <= 1'b1;
               rise_at <= cnt;
            end
            if (early_data || hold_bad || late_done || width_bad || wr_done) begin
               bad <= 1'b1;
            end
            if (last) begin
               cyc.done <= 1'b1;
               cyc.fail <= bad | (cyc.is_read & (~seen | (cap != cyc.wdata)));
            end
         end
      end
   end
endmodule

// file: sim/pwm_tester_assertions.sv
/* Assertions on the tester pins: strobe width and spacing, pins held
   across the strobe, stop on mismatch. Assumes pwm_pkg is compiled first. */
`timescale 1ns/1ps
module pwm_tester_chk
   import pwm_pkg::*;
(
   input wire logic              core_clk,     // Clock.
   input wire logic              resetn,       // Reset, active low.
   input wire pwm_pkg::pwm_pat_e pattern,      // Pattern.
   input wire logic              man_read,     // Manual direction.
   input wire logic [ADDR_W-1:0] man_addr,     // Manual address.
   input wire logic [SEL_W-1:0]  sel_code,     // Select request.
   input wire logic              active,       // Busy.
   input wire logic              error,        // Mismatch.
   input wire logic [ADDR_W-1:0] err_addr,     // Failing address.
   input wire logic              start_pulse,  // Strobe.
   input wire logic              wr_n_rd,      // High for read.
   input wire logic [ADDR_W-1:0] mem_addr,     // Address pins.
   input wire logic [DATA_W-1:0] data_in_bits, // Data pins.
   input wire logic [SEL_W-1:0]  unit_sel      // Select pins.
);
   logic [6:0] hi_cnt;
   logic [6:0] gap_cnt;
   logic       sp_q;
   logic [6:0] next_hi_cnt;
   logic [6:0] next_gap_cnt;
   wire        sp_rise = start_pulse && !sp_q;
   default clocking @(posedge core_clk); endclocking
   default disable iff (!resetn);
   // Reset loads the saturated gap count, so the first strobe after reset always passes the spacing check.
   assign next_hi_cnt  = start_pulse ? hi_cnt + 7'h01 : 7'h00;
   assign next_gap_cnt = sp_rise ? 7'h01 : (gap_cnt == 7'h7F ? gap_cnt : gap_cnt + 7'h01);
   // Helper registers for width and spacing.
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         {hi_cnt, sp_q} <= 8'h00;
         gap_cnt        <= 7'h7F;
      end else begin
         {hi_cnt, sp_q} <= {next_hi_cnt, start_pulse};
         gap_cnt        <= next_gap_cnt;
      end
   end
   chk_strobe_width: assert property ($fell(start_pulse) |-> hi_cnt == STROBE_CLKS)
      else $error("strobe width wrong");
   chk_strobe_gap: assert property (sp_rise |-> gap_cnt >= CYCLE_CLKS)
      else $error("strobes too close");
   chk_pins_held: assert property (start_pulse && sp_q |-> $stable(mem_addr) && $stable(data_in_bits) && $stable(wr_n_rd))
      else $error("pins moved during strobe");
   chk_sel_passed: assert property (unit_sel == sel_code)
      else $error("select pins differ");
   chk_manual_pins: assert property (pattern == PWM_PAT_MANUAL && sp_rise |-> wr_n_rd == man_read && mem_addr == man_addr)
      else $error("manual pins wrong");
   chk_seq_data: assert property (pattern == PWM_PAT_SEQ && sp_rise && !wr_n_rd |-> data_in_bits == ZEROS || data_in_bits == ONES)
      else $error("sequential data not solid");
   chk_stop_on_err: assert property (error |-> !sp_rise)
      else $error("strobe after mismatch");
   chk_err_idle: assert property ($rose(error) |-> ##[0:2] !active)
      else $error("still active after mismatch");
   chk_err_addr_hold: assert property (error && $past(error) |-> $stable(err_addr))
      else $error("failing address moved");
   cov_read: cover property (sp_rise && wr_n_rd);
   cov_write: cover property (sp_rise && !wr_n_rd);
   cov_error: cover property ($rose(error));
endmodule
bind pwm_tester pwm_tester_chk u_chk (.core_clk, .resetn, .pattern, .man_read, .man_addr, .sel_code, .active,
   .error, .err_addr, .start_pulse, .wr_n_rd, .mem_addr, .data_in_bits, .unit_sel);

// file: sim/pwm_mem_model.sv
/* Behavioural memory unit with open-collector outputs and no clock.
   Assumes the bench pulls done_n and dout_n up. */
`timescale 1ns/1ps
module pwm_mem_model
   import pwm_pkg::*;
#(
   parameter int ACC_NS   = 300, // Strobe edge to read-done.
   parameter int DWID_NS  = 300, // Read-done width.
   parameter int DHOLD_NS = 200  // Data hold after read-done.
)(
   input wire logic              pwr,          // Memory power.
   input wire logic              start_pulse,  // Strobe.
   input wire logic              wr_n_rd,      // High for read.
   input wire logic [ADDR_W-1:0] mem_addr,     // Address.
   input wire logic [DATA_W-1:0] data_in_bits, // Data in.
   input wire logic [SEL_W-1:0]  unit_sel,     // Select.
   output wire                   done_n,       // Read-done.
   output wire [DATA_W-1:0]      dout_n        // Data out, low for one.
);
   // Never cleared: contents survive power loss, and no word disturbs another.
   logic [DATA_W-1:0] mem [WORDS];
   logic              done_drv = 1'b0;
   logic [DATA_W-1:0] bits_drv = ZEROS;
   // Outputs only sink current; released lines float to the pull-up.
   assign done_n = done_drv ? 1'b0 : 1'bz;
   for (genvar i = 0; i < DATA_W; i++) begin : g_out
      assign dout_n[i] = bits_drv[i] ? 1'b0 : 1'bz;
   end
   // One access per strobe edge; a read leaves the word in place.
   always @(posedge start_pulse) begin : access
      logic [ADDR_W-1:0] a;
      // Let the pins launched with the strobe settle, and keep every edge of ours off the clock edge.
      #1;
      a = mem_addr;
      if (pwr && unit_sel == SEL_ON) begin
         if (!wr_n_rd) begin
            mem[a] = data_in_bits;
         end else begin
            #(ACC_NS - 20) bits_drv = mem[a];
            #20 done_drv = 1'b1;
            #(DWID_NS) done_drv = 1'b0;
            #(DHOLD_NS) bits_drv = ZEROS;
         end
      end
   end
endmodule

// file: sim/tb.sv
/* Self-checking bench for the tester against the memory model.
   Assumes pwm_pkg, the tester, the model and the checker are compiled. */
`timescale 1ns/1ps
module tb;
   import pwm_pkg::*;
   logic              core_clk, resetn, run, halt, read_seven, man_read, pwr, next_group;
   logic              active, error, start_pulse, wr_n_rd;
   logic              sp_d = 1'b0;
   pwm_pat_e          pattern;
   logic [ADDR_W-1:0] man_addr, err_addr, mem_addr;
   logic [DATA_W-1:0] man_data, data_in_bits;
   logic [SEL_W-1:0]  sel_code, unit_sel;
   logic [1:0]        group;
   tri1               done_n;
   tri1 [DATA_W-1:0]  dout_n;
   logic [30:0]       lg [$]; // Read flag, address and data per strobe.
   int                miscompares, checks;
   pwm_tester dut (.core_clk, .resetn, .clk_en(1'b1), .run, .halt, .next_group, .pattern, .read_seven,
      .man_read, .man_addr, .man_data, .sel_code, .active, .error, .err_addr, .group, .start_pulse, .wr_n_rd,
      .mem_addr, .data_in_bits, .unit_sel, .done_n, .dout_n);
   pwm_mem_model m (.pwr, .start_pulse, .wr_n_rd, .mem_addr, .data_in_bits, .unit_sel, .done_n, .dout_n);
   initial begin
      core_clk = 1'b0;
      forever #12.5 core_clk = ~core_clk;
   end
   // Log every strobe with the pins it launched.
   always @(posedge core_clk) begin
      sp_d <= start_pulse;
      if (start_pulse && !sp_d) lg.push_back({wr_n_rd, mem_addr, data_in_bits});
   end
   task automatic chk(input logic ok, input string msg);
      checks++;
      if (ok !== 1'b1) begin
         miscompares++;
         $display("[FAIL] %0t ns: %s", $time, msg);
      end
   endtask
   task automatic report_and_stop;
      if (miscompares == 0 && checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   // Start a pattern; stop it after n strobes, or wait for it to stop itself.
   task automatic go(input pwm_pat_e p, input int n);
      int i;
      lg.delete();
      pattern = p;
      run = 1'b1;
      @(negedge core_clk) run = 1'b0;
      for (i = 0; i < 5000 && active !== 1'b0 && (n == 0 || lg.size() < n); i++) @(negedge core_clk);
      if (i == 5000) begin
         chk(1'b0, "pattern timed out");
         report_and_stop();
      end
      // Halt is held over at least one edge so it never toggles within one time step.
      halt = 1'b1;
      @(negedge core_clk);
      for (i = 0; i < 200 && active !== 1'b0; i++) @(negedge core_clk);
      halt = 1'b0;
      if (active !== 1'b0) begin
         chk(1'b0, "tester hung");
         report_and_stop();
      end
   endtask
   task automatic t_manual;
      man_read = 1'b0;
      go(PWM_PAT_MANUAL, 0);
      chk(m.mem[man_addr] === man_data, "word not stored");
      chk(lg.size() == 1 && lg[0] === {1'b0, man_addr, man_data}, "write pins");
      man_read = 1'b1;
      go(PWM_PAT_MANUAL, 0);
      chk(error === 1'b0 && lg[0][30] === 1'b1, "read back");
   endtask
   task automatic t_seq(input logic r7);
      int k, j, per;
      logic [30:0] e;
      read_seven = r7;
      per = r7 ? 16 : 4;
      go(PWM_PAT_SEQ, 2 * per + 1);
      chk(error === 1'b0, "sequential error");
      for (k = 0; k < 2 * per + 1; k++) begin
         j = k % per;
         e = {1'b1, 12'(k / per), ZEROS};
         if (j == 0 || j == per / 2) e = {1'b0, 12'(k / per), j == 0 ? ZEROS : ONES};
         chk(lg[k][30:18] === e[30:18] && (e[30] || lg[k][17:0] === e[17:0]), "sequence order");
      end
   endtask
   // Every code but all-ones leaves the memory deaf, so the first read fails.
   task automatic t_select;
      int s;
      for (s = 0; s < 15; s++) begin
         sel_code = 4'(s);
         go(PWM_PAT_SEQ, 0);
         chk(error === 1'b1 && err_addr === 12'h000, "deselected unit answered");
      end
      chk(m.mem[0] === ONES, "deselected write stored");
      sel_code = SEL_ON;
   endtask
   // Single pass writes the chosen data from address 0 upwards.
   task automatic t_single;
      int k;
      man_read = 1'b0;
      go(PWM_PAT_SINGLE, 3);
      for (k = 0; k < 3; k++) begin
         chk(lg[k] === {1'b0, 12'(k), man_data} && m.mem[k] === man_data, "single pass write");
      end
   endtask
   // The disturb test opens by hammering ones; the operator then steps the group.
   task automatic t_worst;
      int k;
      go(PWM_PAT_WORST, 3);
      for (k = 0; k < 3; k++) begin
         chk(lg[k] === {1'b0, 12'(k), ONES}, "hammer pass write");
      end
      next_group = 1'b1;
      @(negedge core_clk) next_group = 1'b0;
      chk(group === 2'd1 && error === 1'b0, "group not advanced");
   endtask
   task automatic t_power;
      pwr = 1'b0;
      resetn = 1'b0;
      repeat (8) @(negedge core_clk);
      chk(start_pulse === 1'b0 && error === 1'b0 && active === 1'b0, "reset state");
      pwr = 1'b1;
      resetn = 1'b1;
      man_read = 1'b1;
      go(PWM_PAT_MANUAL, 0);
      chk(error === 1'b0 && m.mem[man_addr] === man_data, "word lost over power cycle");
   endtask
   initial begin
      {run, halt, read_seven, man_read, resetn, next_group} = 6'h00;
      pwr = 1'b1;
      pattern = PWM_PAT_MANUAL;
      man_addr = 12'h9B7;
      man_data = 18'h2A5C3;
      sel_code = SEL_ON;
      miscompares = 0;
      checks = 0;
      repeat (8) @(negedge core_clk);
      resetn = 1'b1;
      t_manual();
      t_seq(1'b0);
      t_seq(1'b1);
      t_select();
      t_single();
      t_worst();
      t_power();
      report_and_stop();
   end
endmodule
